// file: core/store_load_forwarding_unit.sv
// Store-to-load forwarding and memory ordering for the memory execution cluster.
// Assumes stores allocate in program order, retire oldest first after execution,
// and every load presented is younger than all stores currently allocated.
`timescale 1ns/100ps
module store_load_forwarding_unit #(
   parameter int RQ_DEPTH = 8,
   parameter int LT_DEPTH = 4
) (
   input  wire logic                SYS_CLK,
   input  wire logic                RESET_N,
   input  wire logic                CE,
   input  wire logic                OOO_MODE,
   input  fwd_pkg::load_req_type    LD_REQ,
   input  fwd_pkg::store_alloc_type ST_ALLOC,
   input  fwd_pkg::store_exec_type  ST_EXEC,
   input  wire logic                ST_RETIRE,
   output logic [fwd_pkg::SQ_IDX_W-1:0] ST_ALLOC_IDX,
   output fwd_pkg::load_done_type   LD_DONE,
   output logic                     REPLAY_VALID,
   output fwd_pkg::replay_type      REPLAY_DATA,
   input  wire logic                REPLAY_READY,
   output logic                     REPLAY_FULL,
   output fwd_pkg::flush_type       FLUSH,
   output logic                     ORDER_VIOL_EVENT
);
   localparam int SQ = fwd_pkg::SQ_DEPTH;
   localparam int IW = fwd_pkg::SQ_IDX_W;
   localparam int AW = fwd_pkg::ADDR_W;

   // ***********************************************************
   // Decode helpers
   // ***********************************************************
   function automatic logic [AW:0] nbytes(input logic [fwd_pkg::SIZE_W-1:0] s);
      nbytes = (AW+1)'(1) << s;
   endfunction

   function automatic logic splits(input logic [AW-1:0] a, input logic [fwd_pkg::SIZE_W-1:0] s);
      splits = ((AW+1)'(a[fwd_pkg::LINE_W-1:0]) + nbytes(s)) > (AW+1)'(fwd_pkg::LINE_BYTES);
   endfunction

   function automatic logic overlaps(input logic [AW-1:0] a, input logic [fwd_pkg::SIZE_W-1:0] sa,
                                     input logic [AW-1:0] b, input logic [fwd_pkg::SIZE_W-1:0] sb);
      overlaps = ({1'b0, a} < {1'b0, b} + nbytes(sb)) && ({1'b0, b} < {1'b0, a} + nbytes(sa));
   endfunction

   // ***********************************************************
   // Store queue state
   // ***********************************************************
   logic [SQ-1:0]                  sq_valid;
   logic [SQ-1:0]                  sq_known;
   logic [AW-1:0]                  sq_addr  [SQ];
   logic [fwd_pkg::SIZE_W-1:0]     sq_size  [SQ];
   logic [fwd_pkg::DATA_W-1:0]     sq_data  [SQ];
   logic [fwd_pkg::LAT_W-1:0]      sq_since [SQ];
   logic [IW-1:0]                  head;
   logic [IW-1:0]                  tail;

   // Load tracker for loads that ran past unknown store addresses
   logic [LT_DEPTH-1:0]            lt_valid;
   logic [AW-1:0]                  lt_addr  [LT_DEPTH];
   logic [fwd_pkg::SIZE_W-1:0]     lt_size  [LT_DEPTH];
   logic [fwd_pkg::TAG_W-1:0]      lt_tag   [LT_DEPTH];
   logic [SQ-1:0]                  lt_mask  [LT_DEPTH];

   // Pending forwarded answer waiting for its latency to expire
   fwd_pkg::pend_state_type        pend;
   logic [fwd_pkg::LAT_W-1:0]      pend_cnt;
   fwd_pkg::load_done_type         pend_done;

   // ***********************************************************
   // Per-entry compare
   // ***********************************************************
   logic [SQ-1:0] hit;
   logic [SQ-1:0] unknown;
   logic [SQ-1:0] exec_clear;
   logic [IW-1:0] age [SQ];
   genvar g;
   generate
      for (g = 0; g < SQ; g++) begin : g_cmp
         assign hit[g]     = sq_valid[g] && sq_known[g] &&
                             overlaps(LD_REQ.addr, LD_REQ.size_log2, sq_addr[g], sq_size[g]);
         assign unknown[g] = sq_valid[g] && !sq_known[g];
         assign age[g]     = IW'(g) - head;
         assign exec_clear[g] = ST_EXEC.valid && (ST_EXEC.idx == IW'(g));
      end
   endgenerate

   // Youngest hitting store: largest distance from the oldest entry
   logic [IW-1:0] sel;
   logic          any_hit;
   always_comb begin
      sel     = '0;
      any_hit = 1'b0;
      for (int i = 0; i < SQ; i++) begin
         if (hit[i] && (!any_hit || age[i] >= age[sel])) begin
            sel     = IW'(i);
            any_hit = 1'b1;
         end
      end
   end

   // ***********************************************************
   // Load decision
   // ***********************************************************
   wire ld_v       = LD_REQ.valid;
   wire [fwd_pkg::LAT_W-1:0] lat = OOO_MODE ? fwd_pkg::OOO_FWD_LAT : fwd_pkg::BASE_FWD_LAT;
   wire ld_split   = splits(LD_REQ.addr, LD_REQ.size_log2);
   wire st_split   = splits(sq_addr[sel], sq_size[sel]);
   wire same_start = LD_REQ.addr == sq_addr[sel];
   wire fits       = LD_REQ.size_log2 <= sq_size[sel];
   wire no_split   = !ld_split && !st_split;
   wire fwd_ok     = any_hit && same_start && fits && no_split;
   wire older_unk  = |unknown;
   wire lt_full    = &lt_valid;
   // Out-of-order mode runs ahead of unknown stores while a tracker slot is free
   wire unk_stop   = older_unk && (!OOO_MODE || lt_full);
   wire pend_busy  = pend == fwd_pkg::PEND_WAIT;
   wire done_clash = pend_busy && pend_cnt == 3'h1;                   // Answer port taken by the waiting forward

   fwd_pkg::cause_type cause;
   assign cause = LD_REQ.locked     ? fwd_pkg::CAUSE_LOCK    :
                  LD_REQ.xlate_miss ? fwd_pkg::CAUSE_XLATE   :
                  unk_stop          ? fwd_pkg::CAUSE_UNKNOWN :
                  (any_hit && !no_split) ? fwd_pkg::CAUSE_SPLIT : fwd_pkg::CAUSE_BLOCK;

   // A second forward while one waits is blocked, as is a load that would collide with the waiting answer
   wire must_replay = ld_v && (LD_REQ.locked || LD_REQ.xlate_miss || unk_stop ||
                               (any_hit && !fwd_ok) || (fwd_ok && pend_busy) || done_clash);
   wire issue_fwd   = ld_v && !must_replay && fwd_ok;
   wire issue_mem   = ld_v && !must_replay && !fwd_ok;
   wire track_ld    = ld_v && !must_replay && older_unk;

   // Cycles still to wait beyond the next one, so the answer lands at exec cycle plus latency
   wire [fwd_pkg::LAT_W-1:0] since_sel = sq_since[sel];
   wire [fwd_pkg::LAT_W-1:0] wait_cnt  = (since_sel < lat - 3'h1) ? lat - 3'h1 - since_sel : '0;

   // ***********************************************************
   // Ordering violation check on store address resolution
   // ***********************************************************
   logic [LT_DEPTH-1:0] lt_conflict;
   logic [LT_DEPTH-1:0] lt_hold;
   logic [LT_DEPTH-1:0] lt_free;
   generate
      for (g = 0; g < LT_DEPTH; g++) begin : g_lt
         assign lt_conflict[g] = lt_valid[g] && ST_EXEC.valid && lt_mask[g][ST_EXEC.idx] &&
                                 overlaps(lt_addr[g], lt_size[g], ST_EXEC.addr, ST_EXEC.size_log2);
         assign lt_hold[g] = lt_valid[g] && |(lt_mask[g] & ~exec_clear);
      end
   endgenerate
   wire viol = |lt_conflict;

   // Lowest slot number wins when several tracked loads conflict at once
   logic [fwd_pkg::TAG_W-1:0] viol_tag;
   logic [$clog2(LT_DEPTH)-1:0] lt_slot;
   always_comb begin
      viol_tag = '0;
      lt_slot  = '0;
      for (int i = LT_DEPTH-1; i >= 0; i--) begin
         if (lt_conflict[i]) begin
            viol_tag = lt_tag[i];
         end
         if (!lt_valid[i]) begin
            lt_slot = ($clog2(LT_DEPTH))'(i);
         end
      end
   end
   assign lt_free = ~lt_valid;

   // ***********************************************************
   // Replay queue
   // ***********************************************************
   wire sq_full  = &sq_valid;
   wire st_refuse = ST_ALLOC.valid && sq_full;
   fwd_pkg::replay_type rp_ld;
   fwd_pkg::replay_type rp_st;
   assign rp_ld = '{is_store: 1'b0, addr: LD_REQ.addr, size_log2: LD_REQ.size_log2,
                    tag: LD_REQ.tag, cause: cause};
   assign rp_st = '{is_store: 1'b1, addr: '0, size_log2: '0,
                    tag: ST_ALLOC.tag, cause: fwd_pkg::CAUSE_OVERFLOW};
   logic rq_full;

   load_replay_queue #(.DEPTH(RQ_DEPTH)) u_replay (
      .clk       (SYS_CLK),
      .reset_n   (RESET_N),
      .ce        (CE),
      .push_a    (must_replay),
      .data_a    (rp_ld),
      .push_b    (st_refuse),
      .data_b    (rp_st),
      .out_valid (REPLAY_VALID),
      .out_data  (REPLAY_DATA),
      .out_ready (REPLAY_READY),
      .full      (rq_full)
   );

   // ***********************************************************
   // Store queue update
   // ***********************************************************
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         sq_valid <= '0;
         sq_known <= '0;
         head     <= '0;
         tail     <= '0;
      end else if (CE) begin
         for (int i = 0; i < SQ; i++) begin
            if (sq_since[i] < lat) begin
               sq_since[i] <= sq_since[i] + 3'h1;     // Saturates; older stores are simply ready
            end
         end
         if (ST_ALLOC.valid && !sq_full) begin
            sq_valid[tail] <= 1'b1;
            sq_known[tail] <= 1'b0;
            tail           <= tail + IW'(1);
         end
         if (ST_EXEC.valid) begin
            sq_known[ST_EXEC.idx] <= 1'b1;
            sq_addr[ST_EXEC.idx]  <= ST_EXEC.addr;
            sq_size[ST_EXEC.idx]  <= ST_EXEC.size_log2;
            sq_data[ST_EXEC.idx]  <= ST_EXEC.data;
            sq_since[ST_EXEC.idx] <= 3'h1;            // Next cycle is one after execution
         end
         if (ST_RETIRE && sq_valid[head]) begin
            sq_valid[head] <= 1'b0;
            head           <= head + IW'(1);
         end
      end
   end

   // ***********************************************************
   // Load tracker: slots drain as each passed store resolves
   // ***********************************************************
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         lt_valid <= '0;
      end else if (CE) begin
         if (viol) begin
            lt_valid <= '0;                           // Flush re-runs every younger load anyway
         end else begin
            lt_valid <= lt_hold;
            for (int i = 0; i < LT_DEPTH; i++) begin
               lt_mask[i] <= lt_mask[i] & ~exec_clear;
            end
            if (track_ld && OOO_MODE && |lt_free) begin
               lt_valid[lt_slot] <= 1'b1;
               lt_addr[lt_slot]  <= LD_REQ.addr;
               lt_size[lt_slot]  <= LD_REQ.size_log2;
               lt_tag[lt_slot]   <= LD_REQ.tag;
               lt_mask[lt_slot]  <= unknown & ~exec_clear;
            end
         end
      end
   end

   // ***********************************************************
   // Answer, pending forward and flush outputs
   // ***********************************************************
   always_ff @(posedge SYS_CLK) begin
      if (!RESET_N) begin
         pend             <= fwd_pkg::PEND_IDLE;
         pend_cnt         <= '0;
         pend_done        <= '0;
         LD_DONE          <= '0;
         FLUSH            <= '0;
         ORDER_VIOL_EVENT <= 1'b0;
         REPLAY_FULL      <= 1'b0;
         ST_ALLOC_IDX     <= '0;
      end else if (CE) begin
         LD_DONE          <= '0;
         FLUSH            <= '{valid: viol, tag: viol_tag};
         ORDER_VIOL_EVENT <= viol;
         REPLAY_FULL      <= rq_full;
         ST_ALLOC_IDX     <= (ST_ALLOC.valid && !sq_full) ? tail + IW'(1) : tail;
         unique case (pend)
            fwd_pkg::PEND_IDLE: begin
               if (issue_fwd && wait_cnt != '0 && !viol) begin
                  pend      <= fwd_pkg::PEND_WAIT;
                  pend_cnt  <= wait_cnt;
                  pend_done <= '{valid: 1'b1, forwarded: 1'b1, tag: LD_REQ.tag, data: sq_data[sel]};
               end
            end
            fwd_pkg::PEND_WAIT: begin
               pend_cnt <= pend_cnt - 3'h1;
               if (viol) begin
                  pend <= fwd_pkg::PEND_IDLE;                          // Younger work is flushed
               end else if (pend_cnt == 3'h1) begin
                  pend    <= fwd_pkg::PEND_IDLE;
                  LD_DONE <= pend_done;
               end
            end
         endcase
         if (issue_fwd && wait_cnt == '0 && !viol) begin
            LD_DONE <= '{valid: 1'b1, forwarded: 1'b1, tag: LD_REQ.tag, data: sq_data[sel]};
         end else if (issue_mem && !viol) begin
            LD_DONE <= '{valid: 1'b1, forwarded: 1'b0, tag: LD_REQ.tag, data: '0};
         end
      end
   end

   // ***********************************************************
   // Checks
   // ***********************************************************
   fwd_same_start_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      issue_fwd |-> LD_REQ.addr == sq_addr[sel]) else $error("forward with different start");
   fwd_width_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      issue_fwd |-> LD_REQ.size_log2 <= sq_size[sel]) else $error("forward to wider load");
   fwd_no_split_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      (ld_v && any_hit && (ld_split || st_split)) |-> !issue_fwd && must_replay)
      else $error("forward across a line split");
   offset_block_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N || !CE)
      (ld_v && any_hit && !same_start) |=> REPLAY_VALID) else $error("offset load not replayed");
   base_latency_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N || !CE)
      (issue_fwd && !OOO_MODE && since_sel == 3'h1) |-> ##2 (LD_DONE.valid && LD_DONE.forwarded))
      else $error("baseline forward not at store plus three");
   ooo_latency_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N || !CE)
      (issue_fwd && OOO_MODE && since_sel == 3'h1 && !viol) ##1 !viol ##1 !viol |-> ##1 LD_DONE.valid)
      else $error("out-of-order forward not at store plus four");
   ooo_pass_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      (ld_v && OOO_MODE && older_unk && !lt_full && !LD_REQ.locked && !LD_REQ.xlate_miss && !any_hit && !done_clash)
      |-> !must_replay) else $error("load held behind unknown store");
   base_unknown_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
      (ld_v && !OOO_MODE && older_unk) |-> must_replay) else $error("baseline load passed unknown store");
   viol_flush_a: assert property (@(posedge SYS_CLK) disable iff (!RESET_N || !CE)
      viol |=> (FLUSH.valid && ORDER_VIOL_EVENT) ##1 !ORDER_VIOL_EVENT || $past(viol))
      else $error("violation without flush and event");
endmodule // store_load_forwarding_unit

// file: core/fwd_pkg.sv
// Constants and carrier types for the store-to-load forwarding unit.
// Assumes one core clock; the issue pipeline presents at most one load per cycle.
// How it works
// - Forward only when load and store start at the same byte address.
// - Forward only when the load is no wider than the store.
// - No forwarding if the store or the load crosses a cache line.
// - An overlapping load that cannot forward is blocked and sent to the replay queue.
// - Small stores forward only to a load at offset zero.
// - Baseline: a forwarded load executes three cycles after its store.
// - Out-of-order mode: store to forwarded load takes four cycles.
// - Out-of-order mode lets loads pass older stores with unknown addresses.
// - A passed store that turns out to overlap flushes the load and everything younger.
// - Baseline replay covers blocks, splits, locks, translation misses, unknown addresses, overflow.
// - Each ordering violation gives a one-cycle countable event pulse.
package fwd_pkg;
   // ***********************************************************
   // Widths and timing
   // ***********************************************************
   localparam int ADDR_W       = 32;
   localparam int DATA_W       = 128;
   localparam int TAG_W        = 8;
   localparam int SIZE_W       = 3;                 // log2 of access bytes, 1..16 bytes
   localparam int LINE_BYTES   = 64;
   localparam int LINE_W       = 6;
   localparam int SQ_IDX_W     = 3;
   localparam int SQ_DEPTH     = 8;
   localparam int LAT_W        = 3;
   localparam logic [LAT_W-1:0] BASE_FWD_LAT = 3'h3;
   localparam logic [LAT_W-1:0] OOO_FWD_LAT  = 3'h4;

   // ***********************************************************
   // Replay causes, one-hot
   // ***********************************************************
   typedef enum logic [5:0] {
      CAUSE_BLOCK    = 6'h01,
      CAUSE_SPLIT    = 6'h02,
      CAUSE_LOCK     = 6'h04,
      CAUSE_XLATE    = 6'h08,
      CAUSE_UNKNOWN  = 6'h10,
      CAUSE_OVERFLOW = 6'h20
   } cause_type;

   typedef enum logic [1:0] {
      PEND_IDLE = 2'h1,
      PEND_WAIT = 2'h2
   } pend_state_type;

   // ***********************************************************
   // Carriers
   // ***********************************************************
   typedef struct packed {
      logic              valid;
      logic [ADDR_W-1:0] addr;
      logic [SIZE_W-1:0] size_log2;
      logic [TAG_W-1:0]  tag;
      logic              locked;
      logic              xlate_miss;
   } load_req_type;

   typedef struct packed {
      logic              valid;
      logic [TAG_W-1:0]  tag;
   } store_alloc_type;

   typedef struct packed {
      logic                valid;
      logic [SQ_IDX_W-1:0] idx;
      logic [ADDR_W-1:0]   addr;
      logic [SIZE_W-1:0]   size_log2;
      logic [DATA_W-1:0]   data;
   } store_exec_type;

   typedef struct packed {
      logic              valid;
      logic              forwarded;
      logic [TAG_W-1:0]  tag;
      logic [DATA_W-1:0] data;
   } load_done_type;

   typedef struct packed {
      logic              is_store;
      logic [ADDR_W-1:0] addr;
      logic [SIZE_W-1:0] size_log2;
      logic [TAG_W-1:0]  tag;
      cause_type         cause;
   } replay_type;

   typedef struct packed {
      logic             valid;
      logic [TAG_W-1:0] tag;
   } flush_type;
endpackage

// file: core/load_replay_queue.sv
// Replay queue: holds blocked loads and refused stores until the pipeline reissues them.
// Assumes the issue pipeline stops sending work while FULL is high.
`timescale 1ns/100ps
module load_replay_queue #(
   parameter int DEPTH = 8
) (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              ce,
   input  wire logic              push_a,
   input  fwd_pkg::replay_type    data_a,
   input  wire logic              push_b,
   input  fwd_pkg::replay_type    data_b,
   output logic                   out_valid,
   output fwd_pkg::replay_type    out_data,
   input  wire logic              out_ready,
   output logic                   full
);
   localparam int PW = $clog2(DEPTH);

   fwd_pkg::replay_type mem [DEPTH];
   logic [PW-1:0]       rd_ptr;
   logic [PW-1:0]       wr_ptr;
   logic [PW:0]         count;

   wire           pop     = out_valid && out_ready;
   wire [PW-1:0]  wr_next = wr_ptr + PW'(1);
   wire [1:0]     n_push  = {1'b0, push_a} + {1'b0, push_b};

   // Two free slots are kept so both pushes of one cycle always fit
   assign full      = count > (PW+1)'(DEPTH - 2);
   assign out_valid = count != '0;
   assign out_data  = mem[rd_ptr];

   // ***********************************************************
   // Storage and pointers
   // ***********************************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rd_ptr <= '0;
         wr_ptr <= '0;
         count  <= '0;
      end else if (ce) begin
         if (push_a) begin
            mem[wr_ptr] <= data_a;
         end
         if (push_b) begin
            mem[push_a ? wr_next : wr_ptr] <= data_b;
         end
         wr_ptr <= wr_ptr + PW'(n_push);
         rd_ptr <= rd_ptr + PW'(pop);
         count  <= count + (PW+1)'(n_push) - (PW+1)'(pop);
      end
   end
endmodule // load_replay_queue

// file: tb/core_issue_model.sv
// Far-side model: issue pipeline reissuing replayed work, counting events.
// Assumes one core clock; pops the replay head unless told to stall.
`timescale 1ns/100ps
module core_issue_model (
   input  wire logic           clk,
   input  wire logic           reset_n,
   input  wire logic           stall,
   input  wire logic           replay_valid,
   input  fwd_pkg::replay_type replay_data,
   input  wire logic           viol_event,
   output logic                replay_ready,
   output int                  pops,
   output fwd_pkg::replay_type last_pop,
   output int                  evs
);
   // A stalled pipeline lets entries pile up in the queue
   assign replay_ready = ~stall;
   // ***************************************
   // Reissue and event counting
   // ***************************************
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pops <= 0;
         evs  <= 0;
      end else begin
         if (replay_valid && replay_ready) begin
            pops     <= pops + 1;
            last_pop <= replay_data;
         end
         if (viol_event) evs <= evs + 1;
      end
   end
endmodule // core_issue_model

// file: tb/store_load_forwarding_unit_tb.sv
// Self-checking bench for the forwarding unit and its far-side model.
// Assumes the fwd_pkg package is compiled first; CE is held high throughout.
`timescale 1ns/100ps
module store_load_forwarding_unit_tb;
   logic sys_clk = 0, reset_n = 0, ce = 1, ooo_mode = 0, st_retire = 0, stall = 0;
   fwd_pkg::load_req_type    ld_req   = '0;
   fwd_pkg::store_alloc_type st_alloc = '0;
   fwd_pkg::store_exec_type  st_exec  = '0;
   fwd_pkg::load_done_type   ld_done;
   fwd_pkg::replay_type      replay_data, last_pop;
   fwd_pkg::flush_type       flush;
   logic [2:0] alloc_idx;
   logic replay_valid, replay_ready, replay_full, viol_ev;
   int err_count = 0, n_compared = 0, slot = 0, live = 0, want_pops = 0, pops, evs;
   store_load_forwarding_unit dut (.SYS_CLK(sys_clk), .RESET_N(reset_n), .CE(ce), .OOO_MODE(ooo_mode),
      .LD_REQ(ld_req), .ST_ALLOC(st_alloc), .ST_EXEC(st_exec), .ST_RETIRE(st_retire), .ST_ALLOC_IDX(alloc_idx),
      .LD_DONE(ld_done), .REPLAY_VALID(replay_valid), .REPLAY_DATA(replay_data), .REPLAY_READY(replay_ready),
      .REPLAY_FULL(replay_full), .FLUSH(flush), .ORDER_VIOL_EVENT(viol_ev));
   core_issue_model partner (.clk(sys_clk), .reset_n(reset_n), .stall(stall), .replay_valid(replay_valid),
      .replay_data(replay_data), .viol_event(viol_ev), .replay_ready(replay_ready), .pops(pops),
      .last_pop(last_pop), .evs(evs));
   // 100 ns clock
   initial forever #50 sys_clk = ~sys_clk;
   // ***************************************
   // Bus tasks and comparison
   // ***************************************
   task check(input string what, input logic [127:0] exp, input logic [127:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task alloc_st(input logic [7:0] t, output logic [2:0] i);
      @(posedge sys_clk) st_alloc <= '{1'b1, t};
      i = slot[2:0];
      slot++;
      live++;
      @(posedge sys_clk) st_alloc.valid <= 1'b0;
      #1 check("alloc index", slot[2:0], alloc_idx);
   endtask
   task exec_st(input logic [2:0] i, input logic [31:0] a, input logic [2:0] s, input logic [127:0] d);
      @(posedge sys_clk) st_exec <= '{1'b1, i, a, s, d};
      @(posedge sys_clk) st_exec.valid <= 1'b0;
   endtask
   task send_load(input logic [31:0] a, input logic [2:0] s, input logic [7:0] t, input logic lk, input logic xm);
      @(posedge sys_clk) ld_req <= '{1'b1, a, s, t, lk, xm};
      @(posedge sys_clk) ld_req.valid <= 1'b0;
   endtask
   // Counts cycles from the store's execution, the load one cycle later; bounded so a lost answer cannot hang
   task wait_done(output int n);
      n = 2;
      #1;
      while (ld_done.valid !== 1'b1 && n < 12) begin
         @(posedge sys_clk) #1 n++;
      end
   endtask
   task expect_replay(input fwd_pkg::cause_type c, input logic [7:0] t);
      int k;
      k = 0;
      want_pops++;
      while (pops < want_pops && k < 20) begin
         @(posedge sys_clk) #1 k++;
      end
      check("replay cause", c, last_pop.cause);
      check("replay tag", t, last_pop.tag);
   endtask
   task retire_all;
      repeat (live) begin
         @(posedge sys_clk) st_retire <= 1'b1;
         @(posedge sys_clk) st_retire <= 1'b0;
      end
      live = 0;
   endtask
   // Load issued the cycle after its store executes
   task t_fwd(input logic ooo, input int lat);
      logic [2:0] i;
      int n;
      @(posedge sys_clk) ooo_mode <= ooo;
      alloc_st(8'h10, i);
      @(posedge sys_clk) st_exec <= '{1'b1, i, 32'h40, 3'h2, 128'hCAFEF00D};
      @(posedge sys_clk) st_exec.valid <= 1'b0;
      ld_req <= '{1'b1, 32'h40, 3'h2, 8'h21, 1'b0, 1'b0};
      @(posedge sys_clk) ld_req.valid <= 1'b0;
      wait_done(n);
      check("fwd flag", 1, ld_done.forwarded);
      check("fwd tag", 8'h21, ld_done.tag);
      check("fwd data", 128'hCAFEF00D, ld_done.data[31:0]);
      check("fwd cycles", lat, n);
      retire_all;
   endtask
   task t_refuse(input logic [31:0] sa, input logic [2:0] ss, input logic [31:0] la, input logic [2:0] ls,
                 input fwd_pkg::cause_type c);
      logic [2:0] i;
      alloc_st(8'h30, i);
      exec_st(i, sa, ss, 128'h55);
      send_load(la, ls, 8'h31, 1'b0, 1'b0);
      expect_replay(c, 8'h31);
      retire_all;
   endtask
   // Stalled far side: three replays queue up, then drain in order
   task t_causes;
      logic [2:0] i;
      @(posedge sys_clk) stall <= 1'b1;
      ooo_mode <= 1'b0;
      send_load(32'h300, 3'h2, 8'h41, 1'b1, 1'b0);
      send_load(32'h310, 3'h2, 8'h42, 1'b0, 1'b1);
      alloc_st(8'h43, i);
      send_load(32'hC0, 3'h2, 8'h44, 1'b0, 1'b0);
      @(posedge sys_clk) stall <= 1'b0;
      expect_replay(fwd_pkg::CAUSE_LOCK, 8'h41);
      expect_replay(fwd_pkg::CAUSE_XLATE, 8'h42);
      expect_replay(fwd_pkg::CAUSE_UNKNOWN, 8'h44);
      exec_st(i, 32'hC0, 3'h2, 128'h0);
      retire_all;
   endtask
   task t_young;
      logic [2:0] i, j;
      int n;
      alloc_st(8'h50, i);
      alloc_st(8'h51, j);
      exec_st(i, 32'h100, 3'h2, 128'h1111);
      exec_st(j, 32'h100, 3'h2, 128'h2222);
      send_load(32'h100, 3'h2, 8'h52, 1'b0, 1'b0);
      wait_done(n);
      check("young data", 128'h2222, ld_done.data[31:0]);
      retire_all;
   endtask
   // Nine stores in a row: the ninth finds all slots taken and goes to replay
   task t_overflow;
      repeat (9) begin
         @(posedge sys_clk) st_alloc <= '{1'b1, 8'h70};
      end
      @(posedge sys_clk) st_alloc.valid <= 1'b0;
      expect_replay(fwd_pkg::CAUSE_OVERFLOW, 8'h70);
      check("overflow is store", 1, last_pop.is_store);
      check("replay full", 0, replay_full);
      slot += 8;
      check("alloc index full", slot[2:0], alloc_idx);
      live = 8;
      retire_all;
   endtask
   // Load passes an unknown store that then turns out to overlap it
   task t_viol;
      logic [2:0] i;
      int n, e0;
      @(posedge sys_clk) ooo_mode <= 1'b1;
      alloc_st(8'h60, i);
      send_load(32'h200, 3'h2, 8'h66, 1'b0, 1'b0);
      wait_done(n);
      check("pass done", 1, ld_done.valid);
      check("pass flag", 0, ld_done.forwarded);
      e0 = evs;
      exec_st(i, 32'h200, 3'h2, 128'h77);
      n = 0;
      #1;
      while (flush.valid !== 1'b1 && n < 8) begin
         @(posedge sys_clk) #1 n++;
      end
      check("flush tag", 8'h66, flush.tag);
      @(posedge sys_clk) #1 check("viol events", e0 + 1, evs);
      retire_all;
   endtask
   task stop_test;
      $display("Compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Main sequence after five reset cycles
   initial begin
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      t_fwd(1'b0, fwd_pkg::BASE_FWD_LAT);
      t_fwd(1'b1, fwd_pkg::OOO_FWD_LAT);
      t_refuse(32'h80, 3'h0, 32'h80, 3'h1, fwd_pkg::CAUSE_BLOCK);
      t_refuse(32'h38, 3'h3, 32'h3C, 3'h3, fwd_pkg::CAUSE_SPLIT);
      t_refuse(32'h90, 3'h1, 32'h91, 3'h0, fwd_pkg::CAUSE_BLOCK);
      t_causes;
      t_young;
      t_overflow;
      t_viol;
      stop_test;
   end
   // Watchdog well past the few hundred cycles the scenarios need
   initial begin
      #300000;
      err_count++;
      stop_test;
   end
endmodule // store_load_forwarding_unit_tb
